// *** rbx_defs.vh ***
`ifndef RBX_DEFS_VH
`define RBX_DEFS_VH

// ****************************************
// Opcode patterns
// ****************************************
`define RBX_OP_NOT_NEG 8'he7
`define RBX_OP_NOT_OVF 8'he5
`define RBX_OP_NOT_ZERO 8'he1
`define RBX_OP_UNCOND 5'h1a
`define RBX_OP_SET_BIT 4'h8

// ****************************************
// Field positions
// ****************************************
`define RBX_BIT_LSB 9
`define RBX_ACC_BIT 8
`define RBX_SHORT_MSB 7
`define RBX_LONG_MSB 10

// ****************************************
// Addressing
// ****************************************
`define RBX_ILO_LIMIT 8'h5f
`define RBX_ACC_SPLIT 8'h80
`define RBX_ACC_HIGH_BANK 4'hf

// ****************************************
// Phases and reset values
// ****************************************
`define RBX_PH_Q1 2'h0
`define RBX_PH_Q2 2'h1
`define RBX_PH_Q3 2'h2
`define RBX_PH_Q4 2'h3
`define RBX_PC_RESET 21'h000000

`endif

// *** rbx_exec.v ***
// Operation
// - Branch if negative flag clear, opcode e7
// - Branch if overflow flag clear, opcode e5
// - Branch if zero flag clear, opcode e1
// - Short branch offset is signed eight bits
// - Target is PC plus two plus twice offset
// - Conditional branch: one cycle, two if taken
// - Q1 decode, Q2 read, Q3 process, Q4 write
// - Opcode 11010 branches by signed eleven bits
// - Unconditional branch always two cycles
// - Opcode 1000 sets one file bit, flags untouched
// - Access bit selects access or banked register
// - Extended set, a=0, f<=5fh: indexed literal offset
`include "rbx_defs.vh"

module rbx_exec (
    clk,
    resetn,
    instr,
    pc_in,
    flag_negative,
    flag_overflow,
    flag_zero,
    bank_select_register,
    index_base,
    ext_set_enable,
    phase,
    pc_out,
    pc_load,
    instr_busy,
    bit_set_done,
    last_write_addr
);
    input wire clk;
    input wire resetn;
    input wire [15:0] instr;
    input wire [20:0] pc_in;
    input wire flag_negative;
    input wire flag_overflow;
    input wire flag_zero;
    input wire [3:0] bank_select_register;
    input wire [11:0] index_base;
    input wire ext_set_enable;
    output reg [1:0] phase;
    output reg [20:0] pc_out;
    output reg pc_load;
    output reg instr_busy;
    output reg bit_set_done;
    output reg [11:0] last_write_addr;

    // ST_NOP is the idle second cycle of a taken branch; the bus word is ignored there
    localparam ST_RUN = 1'b0;
    localparam ST_NOP = 1'b1;

    // ****************************************
    // Reset release
    // ****************************************
    reg rst_meta_reg;
    reg rst_sync_reg;
    // Release is two clocks late, so the phase counter always restarts cleanly at Q1
    wire rst_n = rst_sync_reg;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    // Twice offset, sign extended to the counter width
    function [20:0] rel_target;
        input [20:0] pc;
        input [10:0] off;
        begin
            rel_target = pc + 21'h000002 + {{9{off[10]}}, off, 1'b0};
        end
    endfunction

    // Short branch offset widened to the long field, sign kept
    function [10:0] short_off;
        input [7:0] n;
        begin
            short_off = {{3{n[`RBX_SHORT_MSB]}}, n};
        end
    endfunction

    // Long form decode, used at fetch and again for the literal read
    function is_long_br;
        input [15:0] w;
        begin
            is_long_br = (w[15:11] == `RBX_OP_UNCOND);
        end
    endfunction

    // Limitation: the indexed sum wraps in twelve bits
    function [11:0] file_addr;
        input a;
        input [7:0] f;
        input ext;
        input [3:0] bank;
        input [11:0] base;
        begin
            if (!a && ext && (f <= `RBX_ILO_LIMIT)) begin
                file_addr = base + {4'h0, f};
            end else if (!a) begin
                // Access bank: low half in bank 0, high half in the top bank
                file_addr = (f < `RBX_ACC_SPLIT) ? {4'h0, f} : {`RBX_ACC_HIGH_BANK, f};
            end else begin
                file_addr = {bank, f};
            end
        end
    endfunction

    // ****************************************
    // Decode
    // ****************************************
    reg state_reg;
    reg [15:0] ir_reg;
    reg take_reg;
    reg [20:0] target_reg;
    reg [11:0] addr_reg;
    reg [7:0] mod_reg;
    reg is_set_reg;

    // Flags, bank and base count only as sampled with the word in Q1
    wire [7:0] hi = instr[15:8];
    wire is_not_neg = (hi == `RBX_OP_NOT_NEG);
    wire is_not_ovf = (hi == `RBX_OP_NOT_OVF);
    wire is_not_zero = (hi == `RBX_OP_NOT_ZERO);
    wire is_uncond = is_long_br(instr);
    wire is_set_bit = (instr[15:12] == `RBX_OP_SET_BIT);
    wire cond = (is_not_neg & ~flag_negative) | (is_not_ovf & ~flag_overflow) | (is_not_zero & ~flag_zero);

    wire [7:0] rd_data;
    wire [2:0] bit_idx = ir_reg[11:`RBX_BIT_LSB];
    // Strobe only in Q4 of a live cycle, so a nop cycle never disturbs memory
    wire wr_en = is_set_reg && state_reg == ST_RUN && phase == `RBX_PH_Q4;

    rbx_file_ram u_ram (
        .clk(clk),
        .rd_addr(addr_reg),
        .rd_data(rd_data),
        .wr_en(wr_en),
        .wr_addr(addr_reg),
        .wr_data(mod_reg)
    );

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= `RBX_PH_Q1;
            state_reg <= ST_RUN;
            ir_reg <= 16'h0000;
            take_reg <= 1'b0;
            target_reg <= `RBX_PC_RESET;
            addr_reg <= 12'h000;
            mod_reg <= 8'h00;
            is_set_reg <= 1'b0;
            pc_out <= `RBX_PC_RESET;
            pc_load <= 1'b0;
            instr_busy <= 1'b0;
            bit_set_done <= 1'b0;
            last_write_addr <= 12'h000;
        end else begin
            phase <= phase + 2'h1;
            pc_load <= 1'b0;
            bit_set_done <= 1'b0;
            case (phase)
                `RBX_PH_Q1: begin
                    if (state_reg == ST_RUN) begin
                        // Decode and latch everything the cycle needs
                        ir_reg <= instr;
                        // Unknown opcodes leave take and set clear and so do nothing
                        take_reg <= cond | is_uncond;
                        is_set_reg <= is_set_bit;
                        addr_reg <= file_addr(instr[`RBX_ACC_BIT], instr[7:0], ext_set_enable,
                                              bank_select_register, index_base);
                    end
                end
                `RBX_PH_Q2: begin
                    // Read the literal; short forms sign extend from bit 7
                    if (state_reg == ST_RUN) begin
                        if (is_long_br(ir_reg)) begin
                            target_reg <= rel_target(pc_in, ir_reg[`RBX_LONG_MSB:0]);
                        end else begin
                            target_reg <= rel_target(pc_in, short_off(ir_reg[7:0]));
                        end
                    end
                end
                `RBX_PH_Q3: begin
                    // Register data arrived from the Q2 read
                    if (state_reg == ST_RUN && is_set_reg) begin
                        mod_reg <= rd_data | (8'h01 << bit_idx);
                    end
                end
                `RBX_PH_Q4: begin
                    if (state_reg == ST_NOP) begin
                        state_reg <= ST_RUN;
                        instr_busy <= 1'b0;
                    end else if (take_reg) begin
                        // New counter shows in the next Q1 together with the load strobe
                        pc_out <= target_reg;
                        pc_load <= 1'b1;
                        state_reg <= ST_NOP;
                        instr_busy <= 1'b1;
                        take_reg <= 1'b0;
                    end else if (is_set_reg) begin
                        bit_set_done <= 1'b1;
                        last_write_addr <= addr_reg;
                        is_set_reg <= 1'b0;
                    end
                end
                default: begin
                    phase <= `RBX_PH_Q1;
                end
            endcase
        end
    end
endmodule // rbx_exec

// *** rbx_exec_sva.sv ***
// ****
// Checks at the exec ports
// ****
module rbx_exec_sva (
    input clk,
    input resetn,
    input [15:0] instr,
    input [20:0] pc_in,
    input flag_negative,
    input flag_zero,
    input [3:0] bank_select_register,
    input [1:0] phase,
    input [20:0] pc_out,
    input pc_load,
    input instr_busy,
    input bit_set_done,
    input [11:0] last_write_addr
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // A full phase loop must be seen first, so the reset sync window is not taken for a fetch
    sequence s_take;
        phase == 2'h0 && !instr_busy && $past(phase) == 2'h3;
    endsequence
    sequence s_nop;
        instr_busy [*4] ##1 !instr_busy;
    endsequence
    a_phase_steps: assert property (
        phase != 2'h0 |=> phase == $past(phase) + 2'h1) else $error("phase order");
    a_load_in_q1: assert property (
        pc_load |-> phase == 2'h0 && instr_busy) else $error("load phase");
    a_load_pulse: assert property (
        pc_load |=> !pc_load) else $error("load width");
    a_nop_cycle: assert property (
        $rose(instr_busy) |-> s_nop) else $error("nop cycle");
    a_long_target: assert property (
        s_take ##0 instr[15:11] == 5'h1a |-> ##4 pc_load && pc_out == $past(pc_in, 3) + 21'h2
        + {{9{$past(instr[10], 4)}}, $past(instr[10:0], 4), 1'b0}) else $error("long target");
    a_nz_target: assert property (
        s_take ##0 instr[15:8] == 8'he1 && !flag_zero |-> ##4 pc_load && pc_out == $past(pc_in, 3)
        + 21'h2 + {{12{$past(instr[7], 4)}}, $past(instr[7:0], 4), 1'b0}) else $error("short target");
    a_nn_skip: assert property (
        s_take ##0 instr[15:8] == 8'he7 && flag_negative |-> ##4 !pc_load && !instr_busy) else $error("skip");
    a_bit_set_write: assert property (
        s_take ##0 instr[15:12] == 4'h8 && instr[8] |-> ##4 bit_set_done && !pc_load
        && last_write_addr == {$past(bank_select_register, 4), $past(instr[7:0], 4)}) else $error("bit set");
    a_done_pulse: assert property (
        bit_set_done |=> !bit_set_done) else $error("done width");
endmodule // rbx_exec_sva

bind rbx_exec rbx_exec_sva chk_u (.clk(clk), .resetn(resetn), .instr(instr), .pc_in(pc_in),
    .flag_negative(flag_negative), .flag_zero(flag_zero), .bank_select_register(bank_select_register),
    .phase(phase), .pc_out(pc_out), .pc_load(pc_load), .instr_busy(instr_busy),
    .bit_set_done(bit_set_done), .last_write_addr(last_write_addr));

// *** rbx_file_ram.v ***
// ****************************************
// Data memory, 4096 bytes, registered read
// ****************************************
module rbx_file_ram (
    clk,
    rd_addr,
    rd_data,
    wr_en,
    wr_addr,
    wr_data
);
    input wire clk;
    input wire [11:0] rd_addr;
    output reg [7:0] rd_data;
    input wire wr_en;
    input wire [11:0] wr_addr;
    input wire [7:0] wr_data;

    reg [7:0] mem [0:4095];

    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // rbx_file_ram

// *** testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, resetn = 0, fn = 0, fv = 0, fz = 0, ext = 1, pc_load, instr_busy, bit_set_done;
    logic [15:0] instr = 0;
    logic [20:0] pc_in = 21'h100, pc_out;
    logic [3:0] bank_sel = 0;
    logic [11:0] ib = 12'h300, last_write_addr;
    logic [1:0] phase;
    logic [15:0] ops [6] = '{16'he700, 16'he500, 16'he100, 16'hd000, 16'h8000, 16'h0000};
    logic [15:0] msk [6] = '{16'hff, 16'hff, 16'hff, 16'h7ff, 16'hfff, 16'hfff};
    logic [15:0] cw [6] = '{16'he780, 16'he57f, 16'hd400, 16'hd3ff, 16'h8e5f, 16'h8060};
    int mismatches = 0, tests_run = 0, cyc = 0, k;
    rbx_exec dut_u (.clk(clk), .resetn(resetn), .instr(instr), .pc_in(pc_in), .flag_negative(fn),
        .flag_overflow(fv), .flag_zero(fz), .bank_select_register(bank_sel), .index_base(ib),
        .ext_set_enable(ext), .phase(phase), .pc_out(pc_out), .pc_load(pc_load),
        .instr_busy(instr_busy), .bit_set_done(bit_set_done), .last_write_addr(last_write_addr));
    // ****
    // Checking and closing
    // ****
    task automatic chk(input logic [20:0] got, input logic [20:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("tests_run %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic run(input logic [15:0] w);
        logic tk, br, bs;
        logic [20:0] tgt;
        logic [11:0] ad;
        while (phase !== 2'h0 || instr_busy !== 1'b0) @(negedge clk);
        instr = w;
        br = w[15:8] == 8'he7 && !fn || w[15:8] == 8'he5 && !fv || w[15:8] == 8'he1 && !fz;
        tk = br || w[15:11] == 5'h1a;
        bs = w[15:12] == 4'h8;
        tgt = pc_in + 21'h2 + (br ? {{12{w[7]}}, w[7:0], 1'b0} : {{9{w[10]}}, w[10:0], 1'b0});
        ad = w[8] ? {bank_sel, w[7:0]} : (ext && w[7:0] <= 8'h5f) ? ib + {4'h0, w[7:0]} : {{4{w[7]}}, w[7:0]};
        repeat (4) @(negedge clk);
        chk(21'(pc_load), 21'(tk));
        chk(21'(phase), 21'h0);
        chk(21'(instr_busy), 21'(tk));
        if (tk) chk(pc_out, tgt);
        chk(21'(bit_set_done), 21'(bs));
        if (bs) chk(21'(last_write_addr), 21'(ad));
        $display("test %h done", w);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            mismatches++;
            end_of_test;
        end
    end
    initial begin
        forever #12.5 clk = ~clk;
    end
    initial begin
        void'($urandom(35));
        repeat (20) @(negedge clk);
        resetn = 1;
        repeat (8) @(negedge clk);
        // Offset extremes and the indexed-window edge first
        foreach (cw[i]) run(cw[i]);
        repeat (60) begin
            {fn, fv, fz, ext, bank_sel} = 8'($urandom);
            pc_in = 21'($urandom);
            ib = 12'($urandom);
            k = $urandom_range(5);
            run(ops[k] | (16'($urandom) & msk[k]));
        end
        end_of_test;
    end
endmodule // testbench
